// *** hdl/lam_pkg.sv ***
/*
 lam_pkg: register indices, field positions, reset values and encodings of
 the logger alarm and mission control block.
 assumes: APB byte address is four times the register index.
*/
package lam_pkg;
	// register indices; byte address is index times four
	localparam logic [9:0] IDX_TEMP_LOW_LIMIT = 10'h208;
	localparam logic [9:0] IDX_TEMP_HIGH_LIMIT = 10'h209;
	localparam logic [9:0] IDX_HUMID_LOW_LIMIT = 10'h20a;
	localparam logic [9:0] IDX_HUMID_HIGH_LIMIT = 10'h20b;
	localparam logic [9:0] IDX_TEMP_RESULT_LOW = 10'h20c;
	localparam logic [9:0] IDX_TEMP_RESULT_HIGH = 10'h20d;
	localparam logic [9:0] IDX_HUMID_RESULT_LOW = 10'h20e;
	localparam logic [9:0] IDX_HUMID_RESULT_HIGH = 10'h20f;
	localparam logic [9:0] IDX_TEMP_ALARM_CONTROL = 10'h210;
	localparam logic [9:0] IDX_HUMID_ALARM_CONTROL = 10'h211;
	localparam logic [9:0] IDX_CLOCK_CONTROL = 10'h212;
	localparam logic [9:0] IDX_MISSION_CONTROL = 10'h213;
	localparam logic [9:0] IDX_ALARM_FLAGS = 10'h214;
	localparam logic [9:0] IDX_MISSION_STATUS = 10'h215;

	// alarm enable and flag bit positions
	localparam int BIT_LOW_ALARM = 0;
	localparam int BIT_HIGH_ALARM = 1;
	localparam int FLAG_TEMP_LOW = 0;
	localparam int FLAG_TEMP_HIGH = 1;
	localparam int FLAG_HUMID_LOW = 2;
	localparam int FLAG_HUMID_HIGH = 3;
	// clock control bits
	localparam int BIT_OSC_RUN = 0;
	localparam int BIT_FAST_UNITS = 1;
	// mission control bits
	localparam int BIT_TEMP_LOG = 0;
	localparam int BIT_HUMID_LOG = 1;
	localparam int BIT_TEMP_WIDE = 2;
	localparam int BIT_HUMID_WIDE = 3;
	localparam int BIT_WRAP_LOG = 4;
	localparam int BIT_ALARM_START = 5;
	// mission status bits
	localparam int BIT_STAT_ACTIVE = 1;
	localparam int BIT_STAT_WAITING = 4;

	// fixed read values of unused bits
	localparam logic [7:0] HUMID_CTL_FILL = 8'hfc;
	localparam logic [7:0] MISSION_CTL_FILL = 8'hc0;
	localparam logic [7:0] FLAGS_FILL = 8'h70;
	localparam logic [7:0] STATUS_FILL = 8'hc0;

	// reset values
	localparam logic [7:0] LIMIT_RST = 8'h00;
	localparam logic [1:0] ENABLE_RST = 2'h0;
	localparam logic [5:0] MISSION_CTL_RST = 6'h00;

	typedef enum {SEQ_IDLE, SEQ_T_HI, SEQ_T_LO, SEQ_H_HI, SEQ_H_LO} lam_seq_e;
endpackage : lam_pkg

// *** hdl/lam_mission_ctl.sv ***
/*
 lam_mission_ctl: alarm thresholds, alarm flags, clock and mission control
 registers behind an APB slave, plus the log byte sequencer.
 assumes: a command decoder gives one-cycle command pulses, the converter
 gives one-cycle sample pulses with both results, and the log address
 logic reports a full log memory.
*/
`timescale 1ns/1ns

// Overview of operation
// R1: in a humidity-logging mission the humidity high byte is always logged.
// R2: the humidity low byte is logged only in 16-bit humidity format.
// R3: humidity alarms compare only the humidity high byte.
// R4: humidity thresholds compare against the raw uncorrected sensor value.
// R5: enabled high temperature alarm: result >= limit sets its flag.
// R6: enabled low temperature alarm: result <= limit sets its flag.
// R7: enabled high humidity alarm: value >= limit sets its flag.
// R8: enabled low humidity alarm: value <= limit sets its flag.
// R9: humidity alarm control: bit1 high, bit0 low; bits 2..7 read one.
// R10: temperature alarm and clock control bits 2..7 read zero.
// R11: during a mission limits and control registers ignore writes.
// R12: clock control bit 1 picks seconds (1) or minutes (0).
// R13: clock control bit 0 runs the oscillator; zero stops it.
// R14: forced conversion or mission start sets the oscillator bit.
// R15: host clears the oscillator bit when idle, keeps it set otherwise.
// R16: alarm start waits with 8-bit conversions; alarming sample logged first.
// R17: samples taken while waiting for the alarm are not counted.
// R18: alarm start works only with temperature logging enabled.
// R19: wrap enabled: logging continues over the oldest data when full.
// R20: no wrap and log full: logging and conversions stop, mission stays.
// R21: mission control bit 3 picks 8- or 16-bit humidity log format.
// R22: comparisons are unsigned bytes; alarm flags stay set until cleared.
module lam_mission_ctl
	import lam_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// command pulses
	input wire logic startMissionCmd,
	input wire logic stopMissionCmd,
	input wire logic forcedConvCmd,
	input wire logic clearMemoryCmd,
	// conversion results
	input wire logic sampleValid,
	input wire logic [15:0] sampleTemp,
	input wire logic [15:0] sampleHumid,
	// log memory
	input wire logic logFull,
	output logic logWrite,
	output logic [7:0] logData,
	output logic wrapLogEnable,
	output logic sampleCountInc,
	// clock and conversion control, mission state and alarm flags
	output logic oscRunEnable,
	output logic fastSampleUnits,
	output logic convEnable,
	output logic convNarrow,
	output logic missionActive,
	output logic [3:0] alarmFlags
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0] tempLowLimit_r, tempHighLimit_r;
	logic [7:0] humidLowLimit_r, humidHighLimit_r;
	logic [15:0] tempResult_r, humidResult_r, capTemp_r, capHumid_r;
	logic [1:0] tempAlarmEn_r, humidAlarmEn_r, clockCtl_r;
	logic [5:0] missionCtl_r;
	logic [3:0] flags_r;
	logic missionActive_r, waiting_r, logStopped_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r, logWrite_r, sampleCountInc_r;
	logic convEnable_r, convNarrow_r;
	logic [7:0] logData_r;
	lam_seq_e seqState_r;

	logic [9:0] regIdx;
	logic aligned, wrEn, rdHit;
	logic [7:0] rdMux, wrByte;
	logic tHiHit, tLoHit, hHiHit, hLoHit, tempHit, missionSample;
	logic startOk, logAccept, haltLog;

	////////////////////////////////////////////////////////////////////////
	// apb decode
	assign regIdx = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign wrByte = pwdata[7:0];
	// writes land only at the sampled completion edge
	assign wrEn = psel && penable && pready_r && pwrite && !pslverr_r;

	always_comb begin
		rdHit = aligned;
		rdMux = 8'h00;
		case (regIdx)
			IDX_TEMP_LOW_LIMIT: rdMux = tempLowLimit_r;
			IDX_TEMP_HIGH_LIMIT: rdMux = tempHighLimit_r;
			IDX_HUMID_LOW_LIMIT: rdMux = humidLowLimit_r;
			IDX_HUMID_HIGH_LIMIT: rdMux = humidHighLimit_r;
			IDX_TEMP_RESULT_LOW: rdMux = tempResult_r[7:0];
			IDX_TEMP_RESULT_HIGH: rdMux = tempResult_r[15:8];
			IDX_HUMID_RESULT_LOW: rdMux = humidResult_r[7:0];
			IDX_HUMID_RESULT_HIGH: rdMux = humidResult_r[15:8];
			// R10: unused bits zero
			IDX_TEMP_ALARM_CONTROL: rdMux = {6'h00, tempAlarmEn_r};
			// R9: unused bits one
			IDX_HUMID_ALARM_CONTROL: rdMux = HUMID_CTL_FILL | {6'h00, humidAlarmEn_r};
			IDX_CLOCK_CONTROL: rdMux = {6'h00, clockCtl_r};
			IDX_MISSION_CONTROL: rdMux = MISSION_CTL_FILL | {2'h0, missionCtl_r};
			IDX_ALARM_FLAGS: rdMux = FLAGS_FILL | {4'h0, flags_r};
			IDX_MISSION_STATUS: begin
				rdMux = STATUS_FILL;
				rdMux[BIT_STAT_ACTIVE] = missionActive_r;
				rdMux[BIT_STAT_WAITING] = waiting_r;
			end
			default: rdHit = 1'b0;
		endcase
	end

	// one wait-free access phase: answer prepared at the setup edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else if (psel && !penable) begin
			pready_r <= 1'b1;
			pslverr_r <= !rdHit;
			prdata_r <= {24'h000000, rdHit ? rdMux : 8'h00};
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			tempLowLimit_r <= LIMIT_RST;
			tempHighLimit_r <= LIMIT_RST;
			humidLowLimit_r <= LIMIT_RST;
			humidHighLimit_r <= LIMIT_RST;
			tempAlarmEn_r <= ENABLE_RST;
			humidAlarmEn_r <= ENABLE_RST;
			missionCtl_r <= MISSION_CTL_RST;
		// R11: locked while a mission runs
		end else if (wrEn && !missionActive_r) begin
			case (regIdx)
				IDX_TEMP_LOW_LIMIT: tempLowLimit_r <= wrByte;
				IDX_TEMP_HIGH_LIMIT: tempHighLimit_r <= wrByte;
				IDX_HUMID_LOW_LIMIT: humidLowLimit_r <= wrByte;
				IDX_HUMID_HIGH_LIMIT: humidHighLimit_r <= wrByte;
				// R10: upper bits dropped
				IDX_TEMP_ALARM_CONTROL: tempAlarmEn_r <= wrByte[1:0];
				// R9: only enable bits kept
				IDX_HUMID_ALARM_CONTROL: humidAlarmEn_r <= wrByte[1:0];
				IDX_MISSION_CONTROL: missionCtl_r <= wrByte[5:0];
				default: ;
			endcase
		end
	end

	// R14: commands force the oscillator on, over any host write
	always_ff @(posedge mclk) begin
		if (rst) begin
			clockCtl_r <= ENABLE_RST;
		end else if (forcedConvCmd || startOk) begin
			clockCtl_r[BIT_OSC_RUN] <= 1'b1;
		end else if (wrEn && !missionActive_r && regIdx == IDX_CLOCK_CONTROL) begin
			// R12 R13: unit select and oscillator run
			clockCtl_r <= wrByte[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// results and alarm comparisons
	always_ff @(posedge mclk) begin
		if (rst) begin
			tempResult_r <= 16'h0000;
			humidResult_r <= 16'h0000;
		end else if (sampleValid) begin
			tempResult_r <= sampleTemp;
			humidResult_r <= sampleHumid;
		end
	end

	assign missionSample = sampleValid && missionActive_r && !logStopped_r;
	// R5 R6 R22: unsigned byte compare of the temperature high byte
	assign tHiHit = tempAlarmEn_r[BIT_HIGH_ALARM]
		&& (sampleTemp[15:8] >= tempHighLimit_r);
	assign tLoHit = tempAlarmEn_r[BIT_LOW_ALARM]
		&& (sampleTemp[15:8] <= tempLowLimit_r);
	// R3 R4: raw humidity high byte only
	// R7 R8: enabled humidity comparisons
	assign hHiHit = humidAlarmEn_r[BIT_HIGH_ALARM]
		&& (sampleHumid[15:8] >= humidHighLimit_r);
	assign hLoHit = humidAlarmEn_r[BIT_LOW_ALARM]
		&& (sampleHumid[15:8] <= humidLowLimit_r);
	assign tempHit = tHiHit || tLoHit;

	// R22 sticky flags; a new alarm wins over the clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			flags_r <= 4'h0;
		end else begin
			flags_r <= (clearMemoryCmd ? 4'h0 : flags_r)
				| ({hHiHit, hLoHit, tHiHit, tLoHit} & {4{missionSample}});
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mission state
	assign startOk = startMissionCmd && !missionActive_r
		&& (missionCtl_r[BIT_TEMP_LOG] || missionCtl_r[BIT_HUMID_LOG]);
	// R20: full log without wrap halts logging
	assign haltLog = missionSample && logFull && !missionCtl_r[BIT_WRAP_LOG];
	// R16 R17: waiting samples other than the alarming one are neither logged nor counted
	// R19: a full log with wrap keeps accepting
	assign logAccept = missionSample && !haltLog && (seqState_r == SEQ_IDLE)
		&& (!waiting_r || tempHit);

	always_ff @(posedge mclk) begin
		if (rst) begin
			missionActive_r <= 1'b0;
			logStopped_r <= 1'b0;
		end else if (startOk) begin
			missionActive_r <= 1'b1;
			logStopped_r <= 1'b0;
		end else begin
			// R20: mission stays active until stopped
			if (stopMissionCmd)
				missionActive_r <= 1'b0;
			if (haltLog)
				logStopped_r <= 1'b1;
		end
	end

	// waiting survives a stop; it ends with the alarm or is reloaded by the next mission start
	always_ff @(posedge mclk) begin
		if (rst) begin
			waiting_r <= 1'b0;
		end else if (startOk) begin
			// R18: alarm start needs temperature logging
			waiting_r <= missionCtl_r[BIT_ALARM_START]
				&& missionCtl_r[BIT_TEMP_LOG];
		end else if (missionSample && tempHit) begin
			waiting_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			convEnable_r <= 1'b0;
			convNarrow_r <= 1'b0;
			sampleCountInc_r <= 1'b0;
		end else begin
			// R20: conversions end with a halted log
			convEnable_r <= missionActive_r && !logStopped_r && !haltLog;
			// R16: narrow conversions while waiting
			convNarrow_r <= waiting_r;
			// R17: only logged samples count
			sampleCountInc_r <= logAccept;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// log byte sequencer; most significant byte goes first
	always_ff @(posedge mclk) begin
		if (rst) begin
			capTemp_r <= 16'h0000;
			capHumid_r <= 16'h0000;
		end else if (logAccept) begin
			capTemp_r <= sampleTemp;
			capHumid_r <= sampleHumid;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			seqState_r <= SEQ_IDLE;
			logWrite_r <= 1'b0;
			logData_r <= 8'h00;
		end else begin
			logWrite_r <= 1'b0;
			case (seqState_r)
				SEQ_IDLE: begin
					if (logAccept)
						seqState_r <= missionCtl_r[BIT_TEMP_LOG] ? SEQ_T_HI : SEQ_H_HI;
				end
				SEQ_T_HI: begin
					logWrite_r <= 1'b1;
					logData_r <= capTemp_r[15:8];
					if (missionCtl_r[BIT_TEMP_WIDE])
						seqState_r <= SEQ_T_LO;
					else if (missionCtl_r[BIT_HUMID_LOG])
						seqState_r <= SEQ_H_HI;
					else
						seqState_r <= SEQ_IDLE;
				end
				SEQ_T_LO: begin
					logWrite_r <= 1'b1;
					logData_r <= capTemp_r[7:0];
					seqState_r <= missionCtl_r[BIT_HUMID_LOG] ? SEQ_H_HI : SEQ_IDLE;
				end
				// R1: humidity high byte always stored
				SEQ_H_HI: begin
					logWrite_r <= 1'b1;
					logData_r <= capHumid_r[15:8];
					// R2 R21: low byte only in wide format
					seqState_r <= missionCtl_r[BIT_HUMID_WIDE] ? SEQ_H_LO : SEQ_IDLE;
				end
				SEQ_H_LO: begin
					logWrite_r <= 1'b1;
					logData_r <= capHumid_r[7:0];
					seqState_r <= SEQ_IDLE;
				end
				default: seqState_r <= SEQ_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign logWrite = logWrite_r;
	assign logData = logData_r;
	assign wrapLogEnable = missionCtl_r[BIT_WRAP_LOG];
	assign sampleCountInc = sampleCountInc_r;
	assign oscRunEnable = clockCtl_r[BIT_OSC_RUN];
	assign fastSampleUnits = clockCtl_r[BIT_FAST_UNITS];
	assign convEnable = convEnable_r;
	assign convNarrow = convNarrow_r;
	assign missionActive = missionActive_r;
	assign alarmFlags = flags_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_temp_high_flag: assert property ( // R5
		missionSample && tHiHit |=> flags_r[FLAG_TEMP_HIGH])
		else $error("high temperature alarm not flagged");
	chk_temp_low_off: assert property ( // R6
		!tempAlarmEn_r[BIT_LOW_ALARM] && !clearMemoryCmd
		&& !flags_r[FLAG_TEMP_LOW] |=> !flags_r[FLAG_TEMP_LOW])
		else $error("low temperature flag set while disabled");
	chk_humid_high_flag: assert property ( // R7
		missionSample && humidAlarmEn_r[BIT_HIGH_ALARM]
		&& sampleHumid[15:8] >= humidHighLimit_r
		|=> flags_r[FLAG_HUMID_HIGH])
		else $error("high humidity alarm not flagged");
	chk_humid_low_flag: assert property ( // R8
		missionSample && humidAlarmEn_r[BIT_LOW_ALARM]
		&& sampleHumid[15:8] <= humidLowLimit_r |=> flags_r[FLAG_HUMID_LOW])
		else $error("low humidity alarm not flagged");
	chk_flags_sticky: assert property ( // R22
		!clearMemoryCmd |=> (flags_r & $past(flags_r)) == $past(flags_r))
		else $error("alarm flag dropped without clear");
	chk_mission_lock: assert property ( // R11
		missionActive_r && !startOk ##1 missionActive_r
		|-> $stable(tempHighLimit_r) && $stable(missionCtl_r))
		else $error("locked register changed in mission");
	chk_osc_forced: assert property ( // R14
		forcedConvCmd |=> clockCtl_r[BIT_OSC_RUN])
		else $error("oscillator not started by command");
	chk_waiting_count: assert property ( // R17
		waiting_r && !tempHit |=> !sampleCountInc_r)
		else $error("sample counted while waiting");
	chk_humid_bytes: assert property ( // R2
		seqState_r == SEQ_H_HI && !missionCtl_r[BIT_HUMID_WIDE]
		|=> logWrite_r ##1 !logWrite_r)
		else $error("humidity low byte written in narrow format");
	chk_log_halt: assert property ( // R20
		haltLog |=> ##1 (!convEnable_r && missionActive_r) [*2])
		else $error("full log did not halt conversions");
	chk_apb_answer: assert property (
		psel && !penable |=> pready_r)
		else $error("apb access phase without ready");

	cov_alarm_start: cover property (waiting_r ##1 !waiting_r && missionActive_r);
	cov_wide_humid: cover property (seqState_r == SEQ_H_LO);
	cov_wrap_full: cover property (missionSample && logFull && logAccept);
	cov_locked_write: cover property (wrEn && missionActive_r);

endmodule : lam_mission_ctl

// *** verif/lam_log_model.sv ***
/*
 lam_log_model: log memory at the far side of the byte sequencer.
 assumes: one byte per logWrite pulse; emptied by the clear memory command.
*/
`timescale 1ns/1ns
module lam_log_model #(
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// log port
	input wire logic logWrite,
	input wire logic [7:0] logData,
	input wire logic wrapLogEnable,
	input wire logic sampleCountInc,
	input wire logic clearMemoryCmd,
	output logic logFull
);
	logic [7:0] mem [0:DEPTH-1];
	int wrPtr;
	int nBytes;
	int nSamples;
	int overrun;
	////////////////////////////////////////////////////////////////////////
	// wrap or overrun
	// full stays set once reached: the sequencer must stop or wrap on it
	always_ff @(posedge mclk) begin
		if (rst || clearMemoryCmd) begin
			wrPtr <= 0;
			nBytes <= 0;
			nSamples <= 0;
			overrun <= 0;
			logFull <= 1'b0;
		end else begin
			if (logWrite) begin
				mem[wrPtr] <= logData;
				wrPtr <= (wrPtr == DEPTH - 1) ? 0 : wrPtr + 1;
				nBytes <= nBytes + 1;
				if (wrPtr == DEPTH - 1)
					logFull <= 1'b1;
				if (logFull && !wrapLogEnable)
					overrun <= overrun + 1;
			end
			if (sampleCountInc)
				nSamples <= nSamples + 1;
		end
	end
endmodule : lam_log_model

// *** verif/tb_lam_mission_ctl.sv ***
/*
 tb_lam_mission_ctl: register, alarm and mission sequences over APB.
 assumes: zero wait state slave, log model of 16 bytes at the far side.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	n_fail++; $display("Error %s exp %0h got %0h", nm, ex, got); end end
module tb_lam_mission_ctl;
	import lam_pkg::*;
	logic mclk = 1'b0, rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, logFull, logWrite, wrapLogEnable;
	logic startMissionCmd = 1'b0, stopMissionCmd = 1'b0;
	logic forcedConvCmd = 1'b0, clearMemoryCmd = 1'b0, sampleValid = 1'b0;
	logic [15:0] sampleTemp = 16'h0, sampleHumid = 16'h0;
	logic [7:0] logData;
	logic sampleCountInc, oscRunEnable, fastSampleUnits;
	logic convEnable, convNarrow, missionActive;
	logic [3:0] alarmFlags;
	logic [7:0] lim [4] = '{8'h3e, 8'h85, 8'h58, 8'h97};
	logic [7:0] expC [4] = '{8'h3e, 8'h00, 8'h58, 8'hf0};
	int checks = 0, n_fail = 0;
	always #10 mclk = ~mclk;
	lam_mission_ctl i_lam_mission_ctl (.*);
	lam_log_model #(.DEPTH(16)) i_lam_log_model (.mclk(mclk), .rst(rst),
		.logWrite(logWrite), .logData(logData),
		.wrapLogEnable(wrapLogEnable), .sampleCountInc(sampleCountInc),
		.clearMemoryCmd(clearMemoryCmd), .logFull(logFull));
	////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic apb(input logic [9:0] idx, input logic wr,
		input logic [7:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge mclk);
		penable <= 1'b1;
		// request stands until ready is seen at a rising edge
		@(posedge mclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		if (n == 50)
			n_fail++;
		rd = prdata;
		err = pslverr;
		@(posedge mclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, d);
	endtask : wr
	task automatic rdChk(input logic [9:0] idx, input logic [7:0] ex,
		input string nm);
		apb(idx, 1'b0, 8'h00);
		`CHK(nm, {24'h0, ex}, rd)
		`CHK("pslverr", 1'b0, err)
	endtask : rdChk
	task automatic cmd(input int k);
		startMissionCmd <= (k == 0);
		stopMissionCmd <= (k == 1);
		forcedConvCmd <= (k == 2);
		clearMemoryCmd <= (k == 3);
		@(posedge mclk);
		{startMissionCmd, stopMissionCmd, forcedConvCmd, clearMemoryCmd} <= 4'h0;
		// registered outputs fed by the new state settle one edge later
		repeat (2) @(posedge mclk);
	endtask : cmd
	task automatic smp(input logic [15:0] t, input logic [15:0] h);
		sampleTemp <= t;
		sampleHumid <= h;
		sampleValid <= 1'b1;
		@(posedge mclk);
		sampleValid <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask : smp
	// byte and sample counts that one sample adds to the log
	task automatic smpChk(input logic [15:0] t, input logic [15:0] h,
		input int nb, input int ns);
		int b0, s0;
		b0 = i_lam_log_model.nBytes;
		s0 = i_lam_log_model.nSamples;
		smp(t, h);
		@(negedge mclk);
		`CHK("log bytes", nb, i_lam_log_model.nBytes - b0)
		`CHK("samples", ns, i_lam_log_model.nSamples - s0)
		@(posedge mclk);
	endtask : smpChk
	task automatic endMission;
		cmd(1);
		cmd(3);
	endtask : endMission
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rdChk(IDX_HUMID_ALARM_CONTROL, 8'hfc, "humid ctl");
		rdChk(IDX_TEMP_ALARM_CONTROL, 8'h00, "temp ctl");
		rdChk(IDX_CLOCK_CONTROL, 8'h00, "clock ctl");
		rdChk(IDX_ALARM_FLAGS, 8'h70, "flags");
		wr(IDX_TEMP_ALARM_CONTROL, 8'hff);
		rdChk(IDX_TEMP_ALARM_CONTROL, 8'h03, "temp ctl");
		wr(IDX_HUMID_ALARM_CONTROL, 8'h00);
		rdChk(IDX_HUMID_ALARM_CONTROL, 8'hfc, "humid ctl");
		wr(IDX_CLOCK_CONTROL, 8'hfe);
		rdChk(IDX_CLOCK_CONTROL, 8'h02, "clock ctl");
		`CHK("fast units", 1'b1, fastSampleUnits)
		`CHK("osc", 1'b0, oscRunEnable)
		wr(IDX_CLOCK_CONTROL, 8'h01);
		`CHK("fast units", 1'b0, fastSampleUnits)
		`CHK("osc", 1'b1, oscRunEnable)
		// host parks the oscillator while idle
		wr(IDX_CLOCK_CONTROL, 8'h00);
		cmd(2);
		`CHK("osc", 1'b1, oscRunEnable)
		apb(10'h3ff, 1'b0, 8'h00);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		// threshold mission in wide formats
		for (int i = 0; i < 4; i++)
			wr(IDX_TEMP_LOW_LIMIT + 10'(i), lim[i]);
		wr(IDX_HUMID_ALARM_CONTROL, 8'h03);
		wr(IDX_CLOCK_CONTROL, 8'h00);
		wr(IDX_MISSION_CONTROL, 8'h0f);
		cmd(0);
		`CHK("osc", 1'b1, oscRunEnable)
		`CHK("active", 1'b1, missionActive)
		wr(IDX_TEMP_HIGH_LIMIT, 8'h11);
		rdChk(IDX_TEMP_HIGH_LIMIT, 8'h85, "temp high lim");
		wr(IDX_MISSION_CONTROL, 8'h00);
		rdChk(IDX_MISSION_CONTROL, 8'hcf, "mission ctl");
		smpChk(16'h6000, 16'h7000, 4, 1);
		`CHK("flags", 4'h0, alarmFlags)
		smpChk(16'hf000, 16'hf010, 4, 1);
		`CHK("flags", 4'ha, alarmFlags)
		smpChk(16'h3e00, 16'h58f0, 4, 1);
		`CHK("flags", 4'hf, alarmFlags)
		for (int i = 0; i < 4; i++)
			`CHK("log byte", expC[i], i_lam_log_model.mem[8 + i])
		smp(16'h6000, 16'h7000);
		rdChk(IDX_ALARM_FLAGS, 8'h7f, "flags");
		rdChk(IDX_HUMID_RESULT_HIGH, 8'h70, "humid res");
		endMission();
		`CHK("flags", 4'h0, alarmFlags)
		// narrow formats, alarms disabled, log runs full
		wr(IDX_TEMP_ALARM_CONTROL, 8'h00);
		wr(IDX_HUMID_ALARM_CONTROL, 8'h00);
		wr(IDX_MISSION_CONTROL, 8'h03);
		cmd(0);
		for (int i = 0; i < 8; i++)
			smpChk(16'hf0ff, 16'h00ff, 2, 1);
		`CHK("flags", 4'h0, alarmFlags)
		smpChk(16'hf000, 16'h0000, 0, 0);
		`CHK("conv", 1'b0, convEnable)
		`CHK("active", 1'b1, missionActive)
		`CHK("osc", 1'b1, oscRunEnable)
		endMission();
		wr(IDX_MISSION_CONTROL, 8'h13);
		cmd(0);
		`CHK("wrap", 1'b1, wrapLogEnable)
		for (int i = 0; i < 8; i++)
			smp(16'h6000, 16'h7000);
		smpChk(16'h6100, 16'h7100, 2, 1);
		`CHK("overrun", 0, i_lam_log_model.overrun)
		endMission();
		// start on temperature alarm
		wr(IDX_TEMP_ALARM_CONTROL, 8'h02);
		wr(IDX_MISSION_CONTROL, 8'h21);
		cmd(0);
		`CHK("narrow", 1'b1, convNarrow)
		rdChk(IDX_MISSION_STATUS, 8'hd2, "status");
		smpChk(16'h6000, 16'h0000, 0, 0);
		smpChk(16'h9000, 16'h0000, 1, 1);
		`CHK("first log", 8'h90, i_lam_log_model.mem[0])
		`CHK("narrow", 1'b0, convNarrow)
		`CHK("flags", 4'h2, alarmFlags)
		endMission();
		wr(IDX_MISSION_CONTROL, 8'h22);
		cmd(0);
		`CHK("narrow", 1'b0, convNarrow)
		smpChk(16'h6000, 16'h5500, 1, 1);
		endMission();
		wr(IDX_CLOCK_CONTROL, 8'h00);
		test_done();
	end
	initial begin
		repeat (5000) @(posedge mclk);
		n_fail++;
		test_done();
	end
endmodule : tb_lam_mission_ctl
